// ### hw/tsa_cfg.svh
// constants of the temperature sensor alarm core
// assumes inclusion by hw/tsa_core.sv and the bench, not by hw/tsa_pkg.sv
// Notes on behaviour
// RULE1: serial port works with bus clock up to 400 kHz; the bench master runs its clock at 2.5 MHz, a 400 ns bit.
// RULE2: three address pins form the low three slave address bits.
// RULE3: conversions start right after reset and run without any command.
// RULE4: over-limit and hysteresis limits are 16-bit read/write registers.
// RULE5: each result stored as 16-bit two's complement, top bit is sign.
// RULE6: temperature sits in bits 15 to 7 of the result register.
// RULE7: results are 9 bits, one step is half a degree.
// RULE8: results are in Celsius; no Fahrenheit conversion in hardware.
// RULE9: result register read returns latest completed conversion.
// RULE10: reading the result never disturbs the running conversion.
// RULE11: every result compared with both limits, alarm updated per mode.
// RULE12: two fault-count bits set a queue of consecutive qualifying results.
// RULE13: polarity bit picks alarm active level; active low after reset.
// RULE14: interrupt mode signals each excursion above the over-limit.
// RULE15: comparator mode acts as thermostat between over and hysteresis.
// RULE16: limit registers keep any written value, usable as storage.
// RULE17: fault codes 00,01,10,11 need 1,2,4,6 results; reset 00.
// RULE18: comparator alarm holds until first result below hysteresis limit.
// RULE19: interrupt alarm cleared by any read; re-arms after results below hysteresis.
// RULE20: result bits 6 to 0 read as zero.
`ifndef TSA_CFG_SVH
`define TSA_CFG_SVH
// register pointers
`define TSA_PTR_TEMP 2'h0
`define TSA_PTR_CONFIG 2'h1
`define TSA_PTR_OVER 2'h2
`define TSA_PTR_HYST 2'h3
// configuration bit positions
`define TSA_CFG_SHUTDOWN 0
`define TSA_CFG_INT_MODE 1
`define TSA_CFG_POLARITY 2
`define TSA_CFG_FQ_LO 3
`define TSA_CFG_FQ_HI 4
// reset values
`define TSA_CONFIG_RST 8'h00
`define TSA_OVER_RST 16'h5000
`define TSA_HYST_RST 16'h4b00
// fixed upper slave address bits
`define TSA_ADDR_HI 4'h9
// fault queue depths
`define TSA_FQ_DEPTH0 3'h1
`define TSA_FQ_DEPTH1 3'h2
`define TSA_FQ_DEPTH2 3'h4
`define TSA_FQ_DEPTH3 3'h6
// conversion period in clock cycles
`define TSA_CONV_CYCLES 100000
`endif

// ### hw/tsa_pkg.sv
// types of the temperature sensor alarm core
// assumes nothing from hw/tsa_cfg.svh; it uses none of its macros
package tsa_pkg;
   typedef enum logic [2:0] {
      TSA_IDLE = 3'b000,
      TSA_ADDR = 3'b001,
      TSA_ACK_ADDR = 3'b010,
      TSA_WRITE = 3'b011,
      TSA_ACK_WRITE = 3'b100,
      TSA_READ = 3'b101,
      TSA_ACK_READ = 3'b110
   } tsa_bus_e;

   typedef struct packed {
      logic scl_s1;
      logic scl_s2;
      logic scl_d;
      logic sda_s1;
      logic sda_s2;
      logic sda_d;
      logic [2:0] addr_s1;
      logic [2:0] addr_s2;
      tsa_bus_e bus;
      logic [3:0] bitcnt;
      logic [7:0] shreg;
      logic [7:0] txbyte;
      logic [7:0] hi_byte;
      logic [1:0] byte_idx;
      logic rw;
      logic [1:0] ptr;
      logic sda_oe;
      logic sda_o;
      logic [7:0] cfg;
      logic [15:0] over_limit;
      logic [15:0] hysteresis_limit;
      logic [8:0] temp;
      logic [31:0] conv_cnt;
      logic stopped;
      logic alarm_act;
      logic look_low;
      logic [2:0] fault_cnt;
      logic alarm_lvl;
      logic alarm_oe;
   } tsa_state_s;
endpackage

// ### hw/tsa_core.sv
// temperature sensor alarm core: two-wire slave, registers, alarm logic
// assumes conv_result comes from the converter on clk; pins are asynchronous
`timescale 1ns/1ps
`include "tsa_cfg.svh"
module tsa_core #(
   parameter int CONV_CYCLES = `TSA_CONV_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // two-wire bus pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // address select straps
   input wire logic addr_sel_bit0,
   input wire logic addr_sel_bit1,
   input wire logic addr_sel_bit2,
   // converter result
   input wire logic [8:0] conv_result,
   // open-drain alarm pin
   output logic thermal_alarm_out,
   output logic thermal_alarm_oe
);
   tsa_pkg::tsa_state_s s;
   tsa_pkg::tsa_state_s n;

   function automatic logic [2:0] fq_depth(input logic [1:0] code);
      case (code)
         2'b00: fq_depth = `TSA_FQ_DEPTH0; // RULE17
         2'b01: fq_depth = `TSA_FQ_DEPTH1;
         2'b10: fq_depth = `TSA_FQ_DEPTH2;
         default: fq_depth = `TSA_FQ_DEPTH3;
      endcase
   endfunction

   function automatic logic [7:0] rd_byte(input tsa_pkg::tsa_state_s st, input logic idx);
      case (st.ptr)
         `TSA_PTR_TEMP: rd_byte = idx ? {st.temp[0], 7'h00} : st.temp[8:1]; // RULE6 RULE20
         `TSA_PTR_CONFIG: rd_byte = st.cfg;
         `TSA_PTR_OVER: rd_byte = idx ? st.over_limit[7:0] : st.over_limit[15:8];
         default: rd_byte = idx ? st.hysteresis_limit[7:0] : st.hysteresis_limit[15:8];
      endcase
   endfunction

   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;
   logic conv_done;
   logic over_exc;
   logic below_hys;
   logic cond;
   logic [2:0] need;

   always_comb
   begin
      n = s;
      // two-stage synchronisers; RULE1 bus rate is far below clk
      n.scl_s1 = scl_in;
      n.scl_s2 = s.scl_s1;
      n.scl_d = s.scl_s2;
      n.sda_s1 = sda_in;
      n.sda_s2 = s.sda_s1;
      n.sda_d = s.sda_s2;
      n.addr_s1 = {addr_sel_bit2, addr_sel_bit1, addr_sel_bit0};
      n.addr_s2 = s.addr_s1;
      scl_rise = s.scl_s2 && !s.scl_d;
      scl_fall = !s.scl_s2 && s.scl_d;
      start_c = s.scl_s2 && s.scl_d && s.sda_d && !s.sda_s2;
      stop_c = s.scl_s2 && s.scl_d && !s.sda_d && s.sda_s2;

      // background conversion timebase, free of any bus activity
      conv_done = 1'b0;
      if (s.stopped)
      begin
         if (!s.cfg[`TSA_CFG_SHUTDOWN])
         begin
            n.stopped = 1'b0;
            n.conv_cnt = 32'h0;
         end
      end
      else if (s.conv_cnt == 32'(CONV_CYCLES - 1)) // RULE3 RULE10
      begin
         conv_done = 1'b1;
         n.conv_cnt = 32'h0;
         n.stopped = s.cfg[`TSA_CFG_SHUTDOWN];
      end
      else
      begin
         n.conv_cnt = s.conv_cnt + 32'h1;
      end

      // limit comparison on the 9 significant bits, signed, half-degree steps
      over_exc = $signed(conv_result) > $signed(s.over_limit[15:7]); // RULE7 RULE8
      below_hys = $signed(conv_result) < $signed(s.hysteresis_limit[15:7]);
      need = fq_depth({s.cfg[`TSA_CFG_FQ_HI], s.cfg[`TSA_CFG_FQ_LO]}); // RULE12
      cond = 1'b0;
      if (conv_done)
      begin
         n.temp = conv_result; // RULE5 RULE9
         if (!s.cfg[`TSA_CFG_INT_MODE])
         begin
            if (s.alarm_act)
            begin
               n.fault_cnt = 3'h0;
               if (below_hys)
               begin
                  n.alarm_act = 1'b0; // RULE15 RULE18
               end
            end
            else
            begin
               cond = over_exc;
            end
         end
         else
         begin
            cond = s.look_low ? below_hys : over_exc; // RULE14 RULE19
         end
         if (s.cfg[`TSA_CFG_INT_MODE] || !s.alarm_act)
         begin
            if (!cond)
            begin
               n.fault_cnt = 3'h0;
            end
            else if (s.fault_cnt + 3'h1 >= need) // RULE11
            begin
               n.fault_cnt = 3'h0;
               n.alarm_act = 1'b1;
               n.look_low = s.cfg[`TSA_CFG_INT_MODE] ? !s.look_low : 1'b0;
            end
            else
            begin
               n.fault_cnt = s.fault_cnt + 3'h1;
            end
         end
      end
      if (s.cfg[`TSA_CFG_INT_MODE] && s.cfg[`TSA_CFG_SHUTDOWN] && s.stopped)
      begin
         n.alarm_act = 1'b0;
      end

      // two-wire slave
      if (start_c)
      begin
         n.bus = tsa_pkg::TSA_ADDR;
         n.bitcnt = 4'h0;
         n.byte_idx = 2'h0;
         n.sda_oe = 1'b0;
      end
      else if (stop_c)
      begin
         n.bus = tsa_pkg::TSA_IDLE;
         n.sda_oe = 1'b0;
      end
      else if (scl_rise)
      begin
         case (s.bus)
            tsa_pkg::TSA_ADDR, tsa_pkg::TSA_WRITE:
            begin
               n.shreg = {s.shreg[6:0], s.sda_s2};
               n.bitcnt = s.bitcnt + 4'h1;
            end
            tsa_pkg::TSA_READ:
            begin
               n.txbyte = {s.txbyte[6:0], 1'b0};
               n.bitcnt = s.bitcnt + 4'h1;
            end
            tsa_pkg::TSA_ACK_READ:
            begin
               if (s.sda_s2)
               begin
                  n.bus = tsa_pkg::TSA_IDLE;
               end
            end
            default:
            begin
            end
         endcase
      end
      else if (scl_fall)
      begin
         case (s.bus)
            tsa_pkg::TSA_ADDR:
            begin
               if (s.bitcnt == 4'h8)
               begin
                  if (s.shreg[7:1] == {`TSA_ADDR_HI, s.addr_s2}) // RULE2
                  begin
                     n.rw = s.shreg[0];
                     n.sda_oe = 1'b1;
                     n.bus = tsa_pkg::TSA_ACK_ADDR;
                  end
                  else
                  begin
                     n.bus = tsa_pkg::TSA_IDLE;
                  end
               end
            end
            tsa_pkg::TSA_ACK_ADDR:
            begin
               n.bitcnt = 4'h0;
               if (s.rw)
               begin
                  n.txbyte = rd_byte(s, 1'b0);
                  n.sda_oe = !n.txbyte[7];
                  n.bus = tsa_pkg::TSA_READ;
                  n.byte_idx = 2'h1;
                  if (s.cfg[`TSA_CFG_INT_MODE])
                  begin
                     // a fresh set by this cycle's conversion wins over the clear
                     n.alarm_act = n.alarm_act && !s.alarm_act; // RULE19
                  end
               end
               else
               begin
                  n.sda_oe = 1'b0;
                  n.bus = tsa_pkg::TSA_WRITE;
               end
            end
            tsa_pkg::TSA_WRITE:
            begin
               if (s.bitcnt == 4'h8)
               begin
                  n.sda_oe = 1'b1;
                  n.bus = tsa_pkg::TSA_ACK_WRITE;
                  n.byte_idx = (s.byte_idx == 2'h2) ? 2'h1 : s.byte_idx + 2'h1;
                  if (s.byte_idx == 2'h0)
                  begin
                     n.ptr = s.shreg[1:0];
                  end
                  else if (s.ptr == `TSA_PTR_CONFIG)
                  begin
                     n.cfg = s.shreg;
                  end
                  else if (s.byte_idx == 2'h1)
                  begin
                     n.hi_byte = s.shreg;
                  end
                  else if (s.ptr == `TSA_PTR_OVER)
                  begin
                     n.over_limit = {s.hi_byte, s.shreg}; // RULE4 RULE16
                  end
                  else if (s.ptr == `TSA_PTR_HYST)
                  begin
                     n.hysteresis_limit = {s.hi_byte, s.shreg}; // RULE4 RULE16
                  end
               end
            end
            tsa_pkg::TSA_ACK_WRITE:
            begin
               n.sda_oe = 1'b0;
               n.bitcnt = 4'h0;
               n.bus = tsa_pkg::TSA_WRITE;
            end
            tsa_pkg::TSA_READ:
            begin
               if (s.bitcnt == 4'h8)
               begin
                  n.sda_oe = 1'b0;
                  n.bus = tsa_pkg::TSA_ACK_READ;
               end
               else
               begin
                  n.sda_oe = !s.txbyte[7];
               end
            end
            tsa_pkg::TSA_ACK_READ:
            begin
               n.bitcnt = 4'h0;
               n.txbyte = rd_byte(s, s.byte_idx[0]);
               n.sda_oe = !n.txbyte[7];
               n.byte_idx = {1'b0, !s.byte_idx[0]};
               n.bus = tsa_pkg::TSA_READ;
            end
            default:
            begin
               n.sda_oe = 1'b0;
            end
         endcase
      end

      // alarm pin level from state and polarity
      n.alarm_lvl = s.alarm_act ? s.cfg[`TSA_CFG_POLARITY]
                                : !s.cfg[`TSA_CFG_POLARITY]; // RULE13
      n.alarm_oe = !n.alarm_lvl;
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s <= '0;
         s.scl_s1 <= 1'b1;
         s.scl_s2 <= 1'b1;
         s.scl_d <= 1'b1;
         s.sda_s1 <= 1'b1;
         s.sda_s2 <= 1'b1;
         s.sda_d <= 1'b1;
         s.bus <= tsa_pkg::TSA_IDLE;
         s.cfg <= `TSA_CONFIG_RST;
         s.over_limit <= `TSA_OVER_RST;
         s.hysteresis_limit <= `TSA_HYST_RST;
         s.alarm_lvl <= 1'b1;
      end
      else
      begin
         s <= n;
      end
   end

   assign sda_out = s.sda_o;
   assign sda_oe = s.sda_oe;
   assign thermal_alarm_out = s.alarm_lvl;
   assign thermal_alarm_oe = s.alarm_oe;
endmodule

// ### tb/tsa_chk.sv
// checker for tsa_core: serial data pin and alarm pin timing
// assumes bind onto tsa_core and a serial clock low for 5 cycles
`timescale 1ns/1ps
module tsa_chk #(
   parameter int CONV_CYCLES = 20
) (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // watched pins
   input wire logic scl_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic thermal_alarm_out,
   input wire logic thermal_alarm_oe
);
   int cyc;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   sequence s_bit_hold;
      sda_oe [*3];
   endsequence
   sequence s_quiet;
      !sda_oe ##1 !sda_oe;
   endsequence
   // cycles since reset, saturating at the first conversion
   always_ff @(posedge clk or negedge arst_n)
      if (!arst_n)
         cyc <= 0;
      else if (cyc < CONV_CYCLES)
         cyc <= cyc + 1;
   a_sda_pull_only: assert property (sda_out == 1'b0)
      else $error("data pin driven high");
   a_alarm_oe_pair: assert property (thermal_alarm_oe == !thermal_alarm_out)
      else $error("alarm enable disagrees with level");
   a_bus_rst_idle: assert property ($rose(arst_n) |-> s_quiet)
      else $error("data pin pulled after reset");
   a_alarm_rst_idle: assert property ($rose(arst_n) |-> thermal_alarm_out)
      else $error("alarm active after reset");
   a_sda_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
      else $error("data pin moved while clock high");
   a_sda_scl_high: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
      else $error("data pin unstable in clock high");
   a_ack_hold: assert property ($rose(sda_oe) |-> s_bit_hold)
      else $error("driven bit too short");
   a_alarm_early: assert property (cyc < CONV_CYCLES |-> thermal_alarm_out)
      else $error("alarm before first conversion");
endmodule
bind tsa_core tsa_chk #(.CONV_CYCLES(CONV_CYCLES)) tsa_chk_i (
   .clk(clk), .arst_n(arst_n), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
   .thermal_alarm_out(thermal_alarm_out), .thermal_alarm_oe(thermal_alarm_oe)
);

// ### tb/tsa_master.sv
// two-wire bus master model: clock 250 ns low, 150 ns high
// assumes a pull-up on the data line only; tasks are called from the bench
`timescale 1ns/1ps
module tsa_master (
   // bus lines
   output logic scl,
   output logic sda_low,
   input wire logic sda
);
   initial
   begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // data set mid low phase, sampled at the end of high phase
   task automatic bit_x(input logic b, output logic r);
      sda_low = !b;
      #100;
      scl = 1'b1;
      #150;
      r = sda;
      scl = 1'b0;
      #150;
   endtask
   task automatic start();
      sda_low = 1'b1;
      #150;
      scl = 1'b0;
      #150;
   endtask
   task automatic stop();
      sda_low = 1'b1;
      #100;
      scl = 1'b1;
      #150;
      sda_low = 1'b0;
      #150;
   endtask
   task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] r,
      output logic nak);
      for (int i = 7; i >= 0; i--)
         bit_x(d[i], r[i]);
      bit_x(last, nak);
   endtask
endmodule

// ### tb/tsa_core_tb.sv
// self-checking bench for tsa_core through its two-wire port and alarm pin
// assumes tsa_master as bus partner; conversions shortened to 20 cycles
`timescale 1ns/1ps
`include "tsa_cfg.svh"
module tsa_core_tb;
   localparam int CONV = 20;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [2:0] sel = 3'h5;
   logic [8:0] temp = 9'h032;
   logic scl;
   logic sda_low;
   logic sda_out;
   logic sda_oe;
   logic alarm_out;
   logic alarm_oe;
   logic [15:0] rd;
   wire logic sda = !(sda_low || sda_oe);
   wire logic alarm_pin = !alarm_oe;
   int n_errors = 0;
   int samples_checked = 0;
   int cycles = 0;
   tsa_core #(.CONV_CYCLES(CONV)) tsa_core_i (
      .clk(clk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
      .sda_oe(sda_oe), .addr_sel_bit0(sel[0]), .addr_sel_bit1(sel[1]),
      .addr_sel_bit2(sel[2]), .conv_result(temp), .thermal_alarm_out(alarm_out),
      .thermal_alarm_oe(alarm_oe)
   );
   tsa_master tsa_master_i (.scl(scl), .sda_low(sda_low), .sda(sda));
   initial
      forever #25 clk = !clk;
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_errors++;
         stop_test();
      end
   end
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #13;
   endtask
   task automatic stop_test();
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cka(input logic e);
      chk({15'h0, alarm_pin}, {15'h0, e});
   endtask
   task automatic adr(input logic [2:0] a, input logic rw, output logic nak);
      logic [7:0] r;
      tsa_master_i.start();
      tsa_master_i.xfer({`TSA_ADDR_HI, a, rw}, 1'b1, r, nak);
   endtask
   task automatic wr(input logic [1:0] p, input int n, input logic [15:0] d);
      logic [7:0] r;
      logic k;
      adr(sel, 1'b0, k);
      tsa_master_i.xfer({6'h0, p}, 1'b1, r, k);
      if (n == 2)
         tsa_master_i.xfer(d[15:8], 1'b1, r, k);
      if (n > 0)
         tsa_master_i.xfer(d[7:0], 1'b1, r, k);
      tsa_master_i.stop();
   endtask
   task automatic rdr(output logic [15:0] d);
      logic k;
      adr(sel, 1'b1, k);
      tsa_master_i.xfer(8'hff, 1'b0, d[15:8], k);
      tsa_master_i.xfer(8'hff, 1'b1, d[7:0], k);
      tsa_master_i.stop();
   endtask
   task automatic t_result();
      logic [8:0] v [3] = '{9'h1ff, 9'h1ce, 9'h0fa};
      rdr(rd);
      chk(rd, 16'h1900);
      foreach (v[i])
      begin
         temp = v[i];
         step(2 * CONV);
         rdr(rd);
         chk(rd, {v[i], 7'h00});
      end
   endtask
   task automatic t_limits();
      wr(2'h2, 0, 16'h0);
      rdr(rd);
      chk(rd, `TSA_OVER_RST);
      wr(2'h3, 2, 16'ha5c3);
      rdr(rd);
      chk(rd, 16'ha5c3);
   endtask
   task automatic t_addr();
      logic k;
      for (int a = 0; a < 8; a++)
      begin
         sel = a[2:0];
         step(4);
         adr(a[2:0], 1'b0, k);
         tsa_master_i.stop();
         chk({15'h0, k}, 16'h0);
         adr(a[2:0] ^ 3'h3, 1'b0, k);
         tsa_master_i.stop();
         chk({15'h0, k}, 16'h1);
      end
      sel = 3'h5;
   endtask
   task automatic t_comp();
      int n [4] = '{1, 2, 4, 6};
      int t;
      temp = 9'h020;
      wr(2'h2, 2, 16'h1900);
      wr(2'h3, 2, 16'h1400);
      for (int c = 0; c < 4; c++)
      begin
         wr(2'h1, 1, {11'h0, c[1:0], 3'h0});
         temp = 9'h040;
         t = 0;
         while (alarm_pin && t < 200)
         begin
            step(1);
            t++;
         end
         chk({15'h0, t > (n[c] - 1) * CONV && t <= n[c] * CONV + 4}, 16'h1);
         temp = 9'h030;
         step(2 * CONV);
         cka(1'b0);
         temp = 9'h020;
         step(CONV + 4);
         cka(1'b1);
      end
      wr(2'h1, 1, 16'h0004);
      temp = 9'h040;
      step(CONV + 4);
      cka(1'b1);
      temp = 9'h020;
      step(CONV + 4);
      cka(1'b0);
   endtask
   task automatic t_int();
      wr(2'h1, 1, 16'h0002);
      temp = 9'h040;
      step(CONV + 4);
      cka(1'b0);
      step(3 * CONV);
      cka(1'b0);
      rdr(rd);
      cka(1'b1);
      step(3 * CONV);
      cka(1'b1);
      temp = 9'h020;
      step(CONV + 4);
      cka(1'b0);
      wr(2'h1, 1, 16'h0003);
      step(CONV + 4);
      cka(1'b1);
      wr(2'h1, 1, 16'h0000);
   endtask
   task automatic t_reset();
      temp = 9'h0b0;
      arst_n = 1'b0;
      step(2);
      arst_n = 1'b1;
      step(1);
      cka(1'b1);
      step(CONV + 4);
      cka(1'b0);
   endtask
   initial
   begin
      step(6);
      arst_n = 1'b1;
      step(4);
      t_result();
      t_limits();
      t_addr();
      t_comp();
      t_int();
      t_reset();
      stop_test();
   end
endmodule
